// ===== rtl/hp_regs_pkg.sv
package hp_regs_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam logic [7:0] OFS_HP_STARTUP = 8'h14;
	localparam logic [7:0] OFS_RSVD_A = 8'h15;
	localparam logic [7:0] OFS_HP_VOLUME = 8'h16;
	localparam logic [7:0] OFS_RSVD_B = 8'h17;
	localparam logic [7:0] OFS_LEFT_VOLUME = 8'h18;
	localparam logic [7:0] RST_HP_STARTUP = 8'h00;
	localparam logic [7:0] RST_HP_VOLUME = 8'h40;
	localparam logic [7:0] RST_LEFT_VOLUME = 8'h00;
	localparam logic [7:0] RSVD_VALUE = 8'h00;
	localparam int STEP_MSB = 7;
	localparam int STEP_LSB = 6;
	localparam int SLOW_MSB = 5;
	localparam int SLOW_LSB = 2;
	localparam int RES_MSB = 1;
	localparam int RES_LSB = 0;
	localparam int FORCE_BIT = 7;
	localparam int ATTEN_MSB = 6;
	localparam int ATTEN_LSB = 0;
	localparam logic [3:0] SLOW_OFF = 4'h0;
	localparam logic [1:0] RES_25K = 2'h0;
	localparam logic [1:0] RES_6K = 2'h1;
	localparam logic [1:0] RES_2K = 2'h2;
	localparam logic [6:0] ATTEN_MUTE = 7'h75;
	localparam logic [1:0] STEP_NONE = 2'h0;
	localparam logic [1:0] STEP_50 = 2'h1;
	localparam logic [1:0] STEP_100 = 2'h2;
	localparam logic [1:0] STEP_200 = 2'h3;
	localparam int CLK_MHZ = 250;
	localparam int STEP_BASE_MS = 50;
	localparam int STEP_BASE_CYCLES = STEP_BASE_MS * 1000 * CLK_MHZ;
	localparam int ROUTE_CNT_W = 28;
endpackage

// ===== rtl/route_timer_if.sv
`timescale 1ns/1ps
interface route_timer_if;
	logic [1:0] stepCode;
	logic stepTick;
	modport regs (
		output stepCode,
		input stepTick
	);
	modport timer (
		input stepCode,
		output stepTick
	);
endinterface

// ===== rtl/soft_route_timer.sv
`timescale 1ns/1ps
module soft_route_timer
	import hp_regs_pkg::*;
#(
	parameter int unsigned STEP50_CYCLES = STEP_BASE_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	route_timer_if.timer rt
);
	logic [ROUTE_CNT_W-1:0] count_q, count_d;
	logic [ROUTE_CNT_W-1:0] limit;
	logic [1:0] code_q, code_d;
	logic tick_q, tick_d;

	// step time doubles per code; code 0 gives no steps at all
	always_comb begin
		limit = ROUTE_CNT_W'(STEP50_CYCLES);
		unique case (rt.stepCode)
			STEP_NONE: limit = '0;
			STEP_50: limit = ROUTE_CNT_W'(STEP50_CYCLES);
			STEP_100: limit = ROUTE_CNT_W'(STEP50_CYCLES * 2);
			STEP_200: limit = ROUTE_CNT_W'(STEP50_CYCLES * 4);
		endcase
	end

	always_comb begin
		code_d = rt.stepCode;
		count_d = count_q + 1'b1;
		tick_d = 1'b0;
		// a new step time restarts the interval so no short first step
		if (rt.stepCode == STEP_NONE || rt.stepCode != code_q) begin
			count_d = '0;
		end else if (count_q >= limit - 1'b1) begin
			count_d = '0;
			tick_d = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			count_q <= '0;
			code_q <= STEP_NONE;
			tick_q <= 1'b0;
		end else begin
			count_q <= count_d;
			code_q <= code_d;
			tick_q <= tick_d;
		end
	end

	assign rt.stepTick = tick_q;
endmodule

// ===== rtl/headphone_startup_input_volume_regs.sv
// Strobed register access was decided locally.
`timescale 1ns/1ps
module headphone_startup_input_volume_regs
	import hp_regs_pkg::*;
#(
	parameter int unsigned STEP50_CYCLES = STEP_BASE_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wrData,
	input wire logic wrEn,
	input wire logic rdEn,
	output logic [DATA_W-1:0] rdData,
	output logic [1:0] softRouteStep,
	output logic softRouteTick,
	output logic [3:0] slowPowerUp,
	output logic rampEnable,
	output logic [1:0] chargeResSel,
	output logic [DATA_W-1:0] headphoneVolume,
	output logic mixerForceOn,
	output logic [6:0] leftInputAtten,
	output logic leftInputMute
);
	logic [DATA_W-1:0] startup_q, startup_d;
	logic [DATA_W-1:0] hpVol_q, hpVol_d;
	logic [DATA_W-1:0] leftVol_q, leftVol_d;
	logic [DATA_W-1:0] rdData_q, rdData_d;
	logic rampEnable_q, rampEnable_d;
	logic leftMute_q, leftMute_d;
	logic routeTick_q, routeTick_d;

	route_timer_if rt ();

	soft_route_timer #(
		.STEP50_CYCLES(STEP50_CYCLES)
	) u_timer (
		.clk(clk),
		.rst(rst),
		.rt(rt)
	);

	// register writes and the decoded flags that follow them
	always_comb begin
		startup_d = startup_q;
		hpVol_d = hpVol_q;
		leftVol_d = leftVol_q;
		if (wrEn) begin
			unique case (addr)
				OFS_HP_STARTUP: startup_d = wrData;
				OFS_HP_VOLUME: hpVol_d = wrData;
				OFS_LEFT_VOLUME: leftVol_d = wrData;
				// reserved and unmapped writes are dropped
				default: ;
			endcase
		end
		rampEnable_d = startup_d[SLOW_MSB:SLOW_LSB] != SLOW_OFF;
		// unused codes above mute also mute: quiet is the safe failure
		leftMute_d = leftVol_d[ATTEN_MSB:ATTEN_LSB] >= ATTEN_MUTE;
		routeTick_d = rt.stepTick;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			startup_q <= RST_HP_STARTUP;
			hpVol_q <= RST_HP_VOLUME;
			leftVol_q <= RST_LEFT_VOLUME;
			rampEnable_q <= 1'b0;
			leftMute_q <= 1'b0;
			routeTick_q <= 1'b0;
		end else begin
			startup_q <= startup_d;
			hpVol_q <= hpVol_d;
			leftVol_q <= leftVol_d;
			rampEnable_q <= rampEnable_d;
			leftMute_q <= leftMute_d;
			routeTick_q <= routeTick_d;
		end
	end

	// read data stand only in the cycle after the strobe, zero otherwise
	always_comb begin
		rdData_d = '0;
		if (rdEn) begin
			unique case (addr)
				OFS_HP_STARTUP: rdData_d = startup_q;
				OFS_RSVD_A: rdData_d = RSVD_VALUE;
				OFS_HP_VOLUME: rdData_d = hpVol_q;
				OFS_RSVD_B: rdData_d = RSVD_VALUE;
				OFS_LEFT_VOLUME: rdData_d = leftVol_q;
				default: rdData_d = '0;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rdData_q <= '0;
		end else begin
			rdData_q <= rdData_d;
		end
	end

	assign rt.stepCode = startup_q[STEP_MSB:STEP_LSB];

	assign rdData = rdData_q;
	assign softRouteStep = startup_q[STEP_MSB:STEP_LSB];
	assign softRouteTick = routeTick_q;
	assign slowPowerUp = startup_q[SLOW_MSB:SLOW_LSB];
	assign rampEnable = rampEnable_q;
	// code 11 is kept as written; the analog side must not see it anyway
	assign chargeResSel = startup_q[RES_MSB:RES_LSB];
	assign headphoneVolume = hpVol_q;
	assign mixerForceOn = leftVol_q[FORCE_BIT];
	assign leftInputAtten = leftVol_q[ATTEN_MSB:ATTEN_LSB];
	assign leftInputMute = leftMute_q;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	sequence s_startup_write;
		wrEn && addr == OFS_HP_STARTUP;
	endsequence

	sequence s_left_write;
		wrEn && addr == OFS_LEFT_VOLUME;
	endsequence

	sequence s_rsvd_write;
		wrEn && (addr == OFS_RSVD_A || addr == OFS_RSVD_B);
	endsequence

	sequence s_hpvol_write;
		wrEn && addr == OFS_HP_VOLUME;
	endsequence

	sequence s_unmapped_read;
		rdEn && addr != OFS_HP_STARTUP && addr != OFS_RSVD_A
			&& addr != OFS_HP_VOLUME && addr != OFS_RSVD_B
			&& addr != OFS_LEFT_VOLUME;
	endsequence

	sequence s_rsvd_read;
		rdEn && (addr == OFS_RSVD_A || addr == OFS_RSVD_B);
	endsequence

	property p_slow_field;
		s_startup_write |=> slowPowerUp == $past(wrData[SLOW_MSB:SLOW_LSB])
			&& rampEnable == ($past(wrData[SLOW_MSB:SLOW_LSB]) != SLOW_OFF);
	endproperty
	a_slow_field: assert property (p_slow_field)
		else $error("slow power-up field or ramp enable wrong");

	property p_res_field;
		s_startup_write ##1 !wrEn [*2] |->
			chargeResSel == $past(wrData[RES_MSB:RES_LSB], 2);
	endproperty
	a_res_field: assert property (p_res_field)
		else $error("charging resistance select did not hold written code");

	property p_rsvd_zero;
		s_rsvd_read |=> rdData == RSVD_VALUE;
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero)
		else $error("reserved register read not zero");

	property p_rsvd_write_ignored;
		s_rsvd_write |=> $stable(headphoneVolume) && $stable(slowPowerUp)
			&& $stable(chargeResSel) && $stable(softRouteStep)
			&& $stable(mixerForceOn) && $stable(leftInputAtten);
	endproperty
	a_rsvd_write_ignored: assert property (p_rsvd_write_ignored)
		else $error("reserved register kept a written value");

	property p_force_mix;
		s_left_write |=> mixerForceOn == $past(wrData[FORCE_BIT]);
	endproperty
	a_force_mix: assert property (p_force_mix)
		else $error("mixer force bit does not follow write");

	property p_atten_read;
		rdEn && addr == OFS_LEFT_VOLUME |=>
			rdData[ATTEN_MSB:ATTEN_LSB] == leftInputAtten
			&& rdData[FORCE_BIT] == mixerForceOn;
	endproperty
	a_atten_read: assert property (p_atten_read)
		else $error("left volume read back differs from register");

	property p_mute_code;
		s_left_write |=> leftInputMute ==
			($past(wrData[ATTEN_MSB:ATTEN_LSB]) >= ATTEN_MUTE);
	endproperty
	a_mute_code: assert property (p_mute_code)
		else $error("mute flag does not match attenuation code");

	property p_no_step_tick;
		(softRouteStep == STEP_NONE) [*3] |-> !softRouteTick;
	endproperty
	a_no_step_tick: assert property (p_no_step_tick)
		else $error("soft-routing tick with zero step time");

	// reset itself must be checked, so the default disable is overridden
	property p_reset_values;
		disable iff (1'h0)
		rst |=> rdData == '0 && !softRouteTick && !rampEnable
			&& !leftInputMute && headphoneVolume == RST_HP_VOLUME
			&& {softRouteStep, slowPowerUp, chargeResSel} == RST_HP_STARTUP
			&& {mixerForceOn, leftInputAtten} == RST_LEFT_VOLUME;
	endproperty
	a_reset_values: assert property (p_reset_values)
		else $error("register outputs not at reset values");

	property p_read_idle;
		!rdEn |=> rdData == '0;
	endproperty
	a_read_idle: assert property (p_read_idle)
		else $error("read data not zero outside a read");

	property p_startup_read;
		rdEn && addr == OFS_HP_STARTUP |=> rdData ==
			$past({softRouteStep, slowPowerUp, chargeResSel});
	endproperty
	a_startup_read: assert property (p_startup_read)
		else $error("startup read back differs from register");

	property p_hpvol_read;
		rdEn && addr == OFS_HP_VOLUME |=> rdData == $past(headphoneVolume);
	endproperty
	a_hpvol_read: assert property (p_hpvol_read)
		else $error("headphone volume read back differs from register");

	property p_unmapped_read;
		s_unmapped_read |=> rdData == '0;
	endproperty
	a_unmapped_read: assert property (p_unmapped_read)
		else $error("unmapped read not zero");

	property p_hpvol_write;
		s_hpvol_write |=> headphoneVolume == $past(wrData);
	endproperty
	a_hpvol_write: assert property (p_hpvol_write)
		else $error("headphone volume does not follow write");

	property p_step_field;
		s_startup_write |=>
			softRouteStep == $past(wrData[STEP_MSB:STEP_LSB]);
	endproperty
	a_step_field: assert property (p_step_field)
		else $error("soft-routing step field does not follow write");

	property p_atten_write;
		s_left_write |=>
			leftInputAtten == $past(wrData[ATTEN_MSB:ATTEN_LSB]);
	endproperty
	a_atten_write: assert property (p_atten_write)
		else $error("attenuation field does not follow write");

	property p_fields_hold;
		!wrEn |=> $stable(headphoneVolume) && $stable(slowPowerUp)
			&& $stable(chargeResSel) && $stable(softRouteStep)
			&& $stable(mixerForceOn) && $stable(leftInputAtten);
	endproperty
	a_fields_hold: assert property (p_fields_hold)
		else $error("register field changed without a write");

	property p_ramp_track;
		rampEnable == (slowPowerUp != SLOW_OFF);
	endproperty
	a_ramp_track: assert property (p_ramp_track)
		else $error("ramp enable disagrees with slow power-up field");

	property p_mute_track;
		leftInputMute == (leftInputAtten >= ATTEN_MUTE);
	endproperty
	a_mute_track: assert property (p_mute_track)
		else $error("mute flag disagrees with attenuation field");

	// a tick of the old code may still be in the pipe one cycle later
	property p_step_restart;
		$changed(softRouteStep) |-> ##2 !softRouteTick;
	endproperty
	a_step_restart: assert property (p_step_restart)
		else $error("soft-routing interval not restarted on code change");
endmodule

// ===== bench/headphone_startup_input_volume_regs_bench.sv
`timescale 1ns/1ps
module headphone_startup_input_volume_regs_bench;
	import hp_regs_pkg::*;
	// short step interval keeps the tick test within a few hundred cycles
	localparam int N = 10;
	logic clk, rst, wrEn, rdEn, tick, ramp, mixForce, mute;
	logic [7:0] addr, wrData, rdData, hpVol, stM, hvM, lvM;
	logic [1:0] step, res;
	logic [3:0] slow;
	logic [6:0] atten;
	logic [7:0] tbl [6] = '{8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h99};
	logic [7:0] vols [6] = '{8'h00, 8'h74, 8'hf5, 8'h75, 8'h3c, 8'h81};
	int fail_count, samples_checked, seed, i, a, b, cyc;

	headphone_startup_input_volume_regs #(.STEP50_CYCLES(N)) dut_u (
		.clk(clk), .rst(rst), .addr(addr), .wrData(wrData), .wrEn(wrEn),
		.rdEn(rdEn), .rdData(rdData), .softRouteStep(step),
		.softRouteTick(tick), .slowPowerUp(slow), .rampEnable(ramp),
		.chargeResSel(res), .headphoneVolume(hpVol),
		.mixerForceOn(mixForce), .leftInputAtten(atten),
		.leftInputMute(mute));

	initial begin
		clk = 0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) cyc <= cyc + 1;

	task close_out();
		$display("checked %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task report(input logic [31:0] got, exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task cmpRd(input logic [7:0] exp);
		report({24'h0, rdData}, {24'h0, exp});
	endtask
	task cmpFld();
		report({6'h0, step, slow, ramp, res, hpVol, mixForce, atten, mute},
			{6'h0, stM[7:6], stM[5:2], stM[5:2] != 4'h0, stM[1:0], hvM,
			lvM[7], lvM[6:0], lvM[6:0] >= 7'h75});
	endtask
	task cmpGap(input int got, exp);
		report(got, exp);
	endtask
	function logic [7:0] mdl(input logic [7:0] ad);
		case (ad)
			OFS_HP_STARTUP: return stM;
			OFS_HP_VOLUME: return hvM;
			OFS_LEFT_VOLUME: return lvM;
			default: return 8'h00;
		endcase
	endfunction
	// software side: random data bent into the codes it may write
	function logic [7:0] legal(input logic [7:0] ad, d);
		logic [7:0] v;
		v = d;
		if (ad == OFS_RSVD_A || ad == OFS_RSVD_B) v = RSVD_VALUE;
		if (ad == OFS_HP_STARTUP && v[1:0] == 2'h3) v[1:0] = RES_6K;
		if (ad == OFS_HP_STARTUP && v[1:0] == RES_25K && v[5:3] == 3'h7)
			v[5] = 1'b0;
		if (ad == OFS_LEFT_VOLUME && v[6:0] > ATTEN_MUTE)
			v[6:0] = ATTEN_MUTE;
		return v;
	endfunction
	task wr(input logic [7:0] ad, d);
		@(posedge clk);
		addr <= ad;
		wrData <= d;
		wrEn <= 1'b1;
		@(posedge clk);
		wrEn <= 1'b0;
		if (ad == OFS_HP_STARTUP) stM = d;
		if (ad == OFS_HP_VOLUME) hvM = d;
		if (ad == OFS_LEFT_VOLUME) lvM = d;
		#1 cmpFld();
	endtask
	task rd(input logic [7:0] ad);
		@(posedge clk);
		addr <= ad;
		rdEn <= 1'b1;
		@(posedge clk);
		rdEn <= 1'b0;
		#1 cmpRd(mdl(ad));
		@(posedge clk);
		#1 cmpRd(8'h00);
	endtask
	task waitTick(output int c);
		int k;
		k = 0;
		while (tick !== 1'b1 && k < 200) begin
			@(posedge clk);
			#1 k++;
		end
		c = cyc;
		@(posedge clk);
		#1;
	endtask

	initial begin
		#80000;
		fail_count++;
		close_out();
	end

	initial begin
		seed = 32'h8bce;
		{rst, wrEn, rdEn, addr, wrData} = {3'b100, 16'h0};
		stM = RST_HP_STARTUP;
		hvM = RST_HP_VOLUME;
		lvM = RST_LEFT_VOLUME;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1 cmpFld();
		for (i = 0; i < 6; i++) rd(tbl[i]);
		$display("test done: reset values");
		for (i = 0; i < 4; i++) begin
			a = $random(seed);
			wr(OFS_HP_STARTUP, {i[1:0], 1'b0, a[2:0], 2'(i % 3)});
			rd(OFS_HP_STARTUP);
		end
		// 6k charging so the long ramp codes stay legal
		for (i = 0; i < 16; i++) wr(OFS_HP_STARTUP, {2'h0, i[3:0], 2'h1});
		$display("test done: startup fields");
		for (i = 0; i < 6; i++) begin
			wr(OFS_LEFT_VOLUME, vols[i]);
			rd(OFS_LEFT_VOLUME);
		end
		$display("test done: left volume");
		for (i = 0; i < 6; i++) begin
			wr(tbl[i], legal(tbl[i], 8'($random(seed))));
			rd(tbl[i]);
		end
		for (i = 0; i < 20; i++) begin
			a = $random(seed);
			b = a[2:0] % 6;
			wr(tbl[b], legal(tbl[b], 8'($random(seed))));
			rd(tbl[a[5:3] % 6]);
		end
		$display("test done: reserved and random");
		// idle code first, so no tick of a random old code skews a gap
		wr(OFS_HP_STARTUP, 8'h00);
		for (i = 1; i < 4; i++) begin
			wr(OFS_HP_STARTUP, {i[1:0], 6'h05});
			waitTick(a);
			waitTick(b);
			cmpGap(b - a, N << (i - 1));
		end
		wr(OFS_HP_STARTUP, 8'h00);
		b = 0;
		repeat (100) begin
			@(posedge clk);
			#1 b += (tick !== 1'b0);
		end
		cmpGap(b, 0);
		$display("test done: soft-route step");
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		stM = RST_HP_STARTUP;
		hvM = RST_HP_VOLUME;
		lvM = RST_LEFT_VOLUME;
		@(posedge clk);
		#1 cmpFld();
		rd(OFS_LEFT_VOLUME);
		rd(OFS_HP_VOLUME);
		$display("test done: mid-run reset");
		close_out();
	end
endmodule
